// ---- hdl/lcs_regs.svh ----
// register map, field positions, reset values and timing figures
// assumes: included by bare name from the light conversion design files
`ifndef LCS_REGS_SVH
`define LCS_REGS_SVH

// -----------------------------------------------------------------
// byte offsets on the register bus
// -----------------------------------------------------------------
`define LCS_OFF_CTRL 8'h00
`define LCS_OFF_HLIM 8'h04
`define LCS_OFF_RES 8'h08
`define LCS_OFF_IST 8'h0c
`define LCS_OFF_IMSK 8'h10

// -----------------------------------------------------------------
// measurement_control fields
// -----------------------------------------------------------------
`define LCS_RANGE_HI 15
`define LCS_RANGE_LO 12
`define LCS_LEN_BIT 11
`define LCS_MODE_HI 10
`define LCS_MODE_LO 9
`define LCS_OVF_BIT 8
`define LCS_DONE_BIT 7
`define LCS_ABOVE_BIT 6
`define LCS_FC_HI 1
`define LCS_FC_LO 0
`define LCS_RANGE_RST 4'hc
`define LCS_RANGE_AUTO 4'hc
`define LCS_RANGE_TOP 4'hb
`define LCS_RANGE_FULLRES 4'h5
`define LCS_LEN_RST 1'h1
`define LCS_MODE_RST 2'h0
`define LCS_FC_RST 2'h0
`define LCS_HLIM_RST 16'hbfff

// -----------------------------------------------------------------
// interrupt status bits
// -----------------------------------------------------------------
`define LCS_IRQ_DONE 0
`define LCS_IRQ_ABOVE 1
`define LCS_IRQ_OVF 2

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define LCS_CLK_KHZ 100000
`define LCS_CONV_SHORT_MS 100
`define LCS_CONV_LONG_MS 800

`endif

// ---- hdl/lcs_pkg.sv ----
// types shared by the light conversion controller and its sequencer
// assumes: nothing beyond a SystemVerilog compiler
package lcs_pkg;
  typedef enum logic [1:0] {
    LCS_MODE_OFF = 2'b00,
    LCS_MODE_SINGLE = 2'b01,
    LCS_MODE_CONT = 2'b10,
    LCS_MODE_CONT2 = 2'b11
  } lcs_mode_t;

  typedef enum logic [1:0] {
    LCS_SEQ_IDLE = 2'b00,
    LCS_SEQ_RUN = 2'b01
  } lcs_seq_state_t;
endpackage

// ---- hdl/lcs_conv_if.sv ----
// start/abort and result handshake between controller and sequencer
// assumes: both ends clocked by hclk
`timescale 1ns/1ps
interface lcs_conv_if;
  logic start;
  logic abort;
  logic long_sel;
  logic [3:0] range_code;
  logic done;
  logic [3:0] res_exp;
  logic [11:0] res_mant;
  logic ovf;

  modport ctrl (
    output start, abort, long_sel, range_code,
    input done, res_exp, res_mant, ovf
  );
  modport seq (
    input start, abort, long_sel, range_code,
    output done, res_exp, res_mant, ovf
  );
endinterface

// ---- hdl/lcs_conv_seq.sv ----
// conversion sequencer: timing, automatic range stepping, overrange
// assumes: light front end inputs already synchronised to hclk
`timescale 1ns/1ps
`include "lcs_regs.svh"
module lcs_conv_seq #(
  parameter int SHORT_CYC = 1,
  parameter int LONG_CYC = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic overload,
  input wire logic [11:0] level,
  lcs_conv_if.seq conv
);
  import lcs_pkg::*;

  lcs_seq_state_t state, next_state;
  logic [31:0] cnt, next_cnt;
  logic [3:0] rng, next_rng;
  logic autor, next_autor;
  logic longc, next_longc;
  logic seen, next_seen;
  logic done, next_done;
  logic [3:0] rexp, next_rexp;
  logic [11:0] rmant, next_rmant;
  logic rovf, next_rovf;

  // low bits lost with short conversions at low ranges
  function automatic logic [11:0] res_mask(input logic [3:0] r,
                                           input logic lng);
    logic [11:0] m;
    m = 12'hfff;
    if (!lng) begin
      if (r == 4'h0) m = 12'hff8;
      else if (r < `LCS_RANGE_FULLRES) m = 12'hffc;
      else if (r == `LCS_RANGE_FULLRES) m = 12'hffe;
    end
    return m;
  endfunction

  // -----------------------------------------------------------------
  // conversion state
  // -----------------------------------------------------------------
  always_comb begin
    logic [31:0] lim;
    lim = longc ? LONG_CYC : SHORT_CYC;
    next_state = state;
    next_cnt = cnt;
    next_rng = rng;
    next_autor = autor;
    next_longc = longc;
    next_seen = seen;
    next_done = 1'b0;
    next_rexp = rexp;
    next_rmant = rmant;
    next_rovf = rovf;
    if (conv.abort) begin
      next_state = LCS_SEQ_IDLE;
    end else if (conv.start) begin
      next_state = LCS_SEQ_RUN;
      next_cnt = 32'h0;
      next_seen = 1'b0;
      next_longc = conv.long_sel;
      next_autor = (conv.range_code == `LCS_RANGE_AUTO);
      if (conv.range_code == `LCS_RANGE_AUTO) next_rng = 4'h0;
      else if (conv.range_code > `LCS_RANGE_TOP) next_rng = `LCS_RANGE_TOP;
      else next_rng = conv.range_code;
    end else if (state == LCS_SEQ_RUN) begin
      if (autor && overload && rng != `LCS_RANGE_TOP) begin
        // step up and restart rather than finish an overloaded pass
        next_rng = rng + 4'h1;
        next_cnt = 32'h0;
        next_seen = 1'b0;
      end else if (cnt + 32'h1 >= lim) begin
        next_state = LCS_SEQ_IDLE;
        next_done = 1'b1;
        next_rexp = rng;
        next_rmant = (overload ? 12'hfff : level) & res_mask(rng, longc);
        next_rovf = seen | overload;
      end else begin
        next_cnt = cnt + 32'h1;
        next_seen = seen | overload;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= LCS_SEQ_IDLE;
      cnt <= 32'h0;
      rng <= 4'h0;
      autor <= 1'b0;
      longc <= 1'b0;
      seen <= 1'b0;
      done <= 1'b0;
      rexp <= 4'h0;
      rmant <= 12'h000;
      rovf <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rng <= next_rng;
      autor <= next_autor;
      longc <= next_longc;
      seen <= next_seen;
      done <= next_done;
      rexp <= next_rexp;
      rmant <= next_rmant;
      rovf <= next_rovf;
    end
  end

  assign conv.done = done;
  assign conv.res_exp = rexp;
  assign conv.res_mant = rmant;
  assign conv.ovf = rovf;
endmodule

// ---- hdl/lcs_ctrl.sv ----
// light conversion control and status with an ahb-lite register slave
// assumes: light front end pins are asynchronous to hclk; single master
`timescale 1ns/1ps
`include "lcs_regs.svh"
module lcs_ctrl #(
  parameter int SHORT_CYC = `LCS_CONV_SHORT_MS * `LCS_CLK_KHZ,
  parameter int LONG_CYC = `LCS_CONV_LONG_MS * `LCS_CLK_KHZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic light_overload,
  input wire logic [11:0] light_level,
  output logic irq
);
  import lcs_pkg::*;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  // two flops per pin; nothing but the second flop reads the first
  logic ovl_s1, ovl_s2;
  logic [11:0] lvl_s1, lvl_s2;

  // level bus may skew between bits; it is only sampled at conversion end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovl_s1 <= 1'b0;
      ovl_s2 <= 1'b0;
      lvl_s1 <= 12'h000;
      lvl_s2 <= 12'h000;
    end else begin
      ovl_s1 <= light_overload;
      ovl_s2 <= ovl_s1;
      lvl_s1 <= light_level;
      lvl_s2 <= lvl_s1;
    end
  end

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  // one carrier for start, abort and the finished result
  lcs_conv_if conv ();

  lcs_conv_seq #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .overload(ovl_s2),
    .level(lvl_s2),
    .conv(conv.seq)
  );

  // expand exponent and mantissa to a common scale for comparing
  function automatic logic [22:0] to_scale(input logic [3:0] e,
                                           input logic [11:0] m);
    logic [3:0] ec;
    ec = (e > `LCS_RANGE_TOP) ? `LCS_RANGE_TOP : e;
    return {11'h000, m} << ec;
  endfunction

  // one decode for every register write hit and the control word read
  function automatic logic hit(input logic valid,
                               input logic [7:0] a,
                               input logic [7:0] off);
    return valid && (a == off);
  endfunction

  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  logic [3:0] range_select, next_range_select;
  logic conversion_length_select, next_conversion_length_select;
  lcs_mode_t mode, next_mode;
  logic overrange_flag, next_overrange_flag;
  logic conversion_done_flag, next_conversion_done_flag;
  logic above_limit_flag, next_above_limit_flag;
  logic [1:0] consecutive_fault_count, next_consecutive_fault_count;
  // fault_run saturates at eight, the longest run any count code needs
  logic [3:0] fault_run, next_fault_run;
  logic [15:0] high_limit, next_high_limit;
  logic [15:0] result, next_result;
  logic [2:0] irq_status, next_irq_status;
  logic [2:0] irq_mask, next_irq_mask;
  logic start, next_start;
  // a write's start waits one cycle behind its abort
  logic start_pend, next_start_pend;
  logic abort, next_abort;
  logic [31:0] hrdata_n;
  logic irq_n;

  // data phase bookkeeping
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;

  logic addr_ok, rd_req, wr_req;
  logic [15:0] ctrl_word;
  logic [3:0] fault_need;

  // a transfer is taken only while the bus is ready for an address phase
  assign addr_ok = hsel && htrans[1] && hready;
  assign rd_req = addr_ok && !hwrite;
  assign wr_req = addr_ok && hwrite;
  assign ctrl_word = {range_select, conversion_length_select, mode,
                      overrange_flag, conversion_done_flag,
                      above_limit_flag, 4'h0, consecutive_fault_count};
  assign fault_need = 4'h1 << consecutive_fault_count;

  // -----------------------------------------------------------------
  // next values: bus writes, conversion results, flags
  // -----------------------------------------------------------------
  always_comb begin
    logic ctrl_wr;
    logic [1:0] wmode;
    logic above;
    ctrl_wr = hit(wr_pend, wr_addr, `LCS_OFF_CTRL);
    wmode = hwdata[`LCS_MODE_HI:`LCS_MODE_LO];
    above = 1'b0;
    next_range_select = range_select;
    next_conversion_length_select = conversion_length_select;
    next_mode = mode;
    next_overrange_flag = overrange_flag;
    next_conversion_done_flag = conversion_done_flag;
    next_above_limit_flag = above_limit_flag;
    next_consecutive_fault_count = consecutive_fault_count;
    next_fault_run = fault_run;
    next_high_limit = high_limit;
    next_result = result;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    next_start = start_pend;
    next_start_pend = 1'b0;
    next_abort = 1'b0;
    next_wr_pend = wr_req;
    next_wr_addr = wr_req ? haddr[7:0] : wr_addr;

    // a read of the control word consumes the done flag
    if (hit(rd_req, haddr[7:0], `LCS_OFF_CTRL))
      next_conversion_done_flag = 1'b0;

    if (ctrl_wr) begin
      next_range_select = hwdata[`LCS_RANGE_HI:`LCS_RANGE_LO];
      next_conversion_length_select = hwdata[`LCS_LEN_BIT];
      next_mode = lcs_mode_t'(wmode);
      next_consecutive_fault_count = hwdata[`LCS_FC_HI:`LCS_FC_LO];
      next_abort = 1'b1;
      if (wmode != LCS_MODE_OFF) begin
        next_conversion_done_flag = 1'b0;
        next_start_pend = 1'b1;
      end
    end

    // limit and mask take the data phase word as it stands; status clears the bits written as one
    if (hit(wr_pend, wr_addr, `LCS_OFF_HLIM))
      next_high_limit = hwdata[15:0];
    if (hit(wr_pend, wr_addr, `LCS_OFF_IMSK))
      next_irq_mask = hwdata[2:0];
    if (hit(wr_pend, wr_addr, `LCS_OFF_IST))
      next_irq_status = irq_status & ~hwdata[2:0];

    // a finishing conversion outranks a clear in the same cycle; one that
    // meets a control write or its abort belongs to the aborted setting
    if (conv.done && !ctrl_wr && !abort) begin
      // values of equal weight in different ranges compare as equal
      above = to_scale(conv.res_exp, conv.res_mant) >
              to_scale(high_limit[15:12], high_limit[11:0]);
      next_result = {conv.res_exp, conv.res_mant};
      next_overrange_flag = conv.ovf;
      next_conversion_done_flag = 1'b1;
      next_irq_status[`LCS_IRQ_DONE] = 1'b1;
      if (conv.ovf) next_irq_status[`LCS_IRQ_OVF] = 1'b1;
      if (above) begin
        if (fault_run < 4'h8) next_fault_run = fault_run + 4'h1;
        if (fault_run + 4'h1 >= fault_need) begin
          next_above_limit_flag = 1'b1;
          next_irq_status[`LCS_IRQ_ABOVE] = 1'b1;
        end
      end else begin
        next_fault_run = 4'h0;
        next_above_limit_flag = 1'b0;
      end
      if (mode == LCS_MODE_SINGLE)
        next_mode = LCS_MODE_OFF;
      else if (mode != LCS_MODE_OFF)
        next_start = 1'b1;
    end
  end

  // register file, flags and the sequencer strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      range_select <= `LCS_RANGE_RST;
      conversion_length_select <= `LCS_LEN_RST;
      mode <= LCS_MODE_OFF;
      overrange_flag <= 1'b0;
      conversion_done_flag <= 1'b0;
      above_limit_flag <= 1'b0;
      consecutive_fault_count <= `LCS_FC_RST;
      fault_run <= 4'h0;
      high_limit <= `LCS_HLIM_RST;
      result <= 16'h0000;
      irq_status <= 3'h0;
      irq_mask <= 3'h0;
      start <= 1'b0;
      start_pend <= 1'b0;
      abort <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      range_select <= next_range_select;
      conversion_length_select <= next_conversion_length_select;
      mode <= next_mode;
      overrange_flag <= next_overrange_flag;
      conversion_done_flag <= next_conversion_done_flag;
      above_limit_flag <= next_above_limit_flag;
      consecutive_fault_count <= next_consecutive_fault_count;
      fault_run <= next_fault_run;
      high_limit <= next_high_limit;
      result <= next_result;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      start <= next_start;
      start_pend <= next_start_pend;
      abort <= next_abort;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
    end
  end

  // abort lands one cycle before the restart so the start is not lost
  assign conv.abort = abort;
  assign conv.start = start;
  assign conv.long_sel = conversion_length_select;
  assign conv.range_code = range_select;

  // -----------------------------------------------------------------
  // bus answer: read data registered at the address phase edge
  // -----------------------------------------------------------------
  always_comb begin
    // unmapped offsets read zero; otherwise the last read word stands
    hrdata_n = hrdata;
    if (rd_req) begin
      unique case (haddr[7:0])
        `LCS_OFF_CTRL: hrdata_n = {16'h0000, ctrl_word};
        `LCS_OFF_HLIM: hrdata_n = {16'h0000, high_limit};
        `LCS_OFF_RES: hrdata_n = {16'h0000, result};
        `LCS_OFF_IST: hrdata_n = {29'h0, irq_status};
        `LCS_OFF_IMSK: hrdata_n = {29'h0, irq_mask};
        default: hrdata_n = 32'h0000_0000;
      endcase
    end
  end

  // interrupt from the values about to land, so irq follows status at once
  always_comb begin
    irq_n = |(next_irq_status & next_irq_mask);
  end

  // the slave never waits and always answers okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
    end else begin
      hrdata <= hrdata_n;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= irq_n;
    end
  end
endmodule

// ---- dv/lcs_ctrl_props.sv ----
// concurrent checks on the light conversion controller register slave
// assumes: bound to lcs_ctrl; one ahb-lite master, single word transfers
`timescale 1ns/1ps
`include "lcs_regs.svh"
module lcs_ctrl_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq
);
  logic dp_v;
  logic dp_w;
  logic [7:0] dp_a;
  logic [4:0] sh_rl;
  logic [1:0] sh_m;
  logic [1:0] sh_fc;
  logic [2:0] sh_msk;
  logic rd_ctrl;
  // ---------------------------------------------------------------
  // shadow of data phases and host-owned fields
  // ---------------------------------------------------------------
  // only host writes change these fields, save mode, which a finished single conversion turns off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_v <= 1'b0;
      dp_w <= 1'b0;
      dp_a <= 8'h00;
      sh_rl <= 5'h19;
      sh_m <= 2'h0;
      sh_fc <= 2'h0;
      sh_msk <= 3'h0;
    end else begin
      dp_v <= hsel && htrans[1] && hready;
      dp_w <= hwrite;
      dp_a <= haddr[7:0];
      if (dp_v && dp_w && dp_a == `LCS_OFF_CTRL) begin
        sh_rl <= hwdata[15:11];
        sh_m <= hwdata[10:9];
        sh_fc <= hwdata[1:0];
      end
      if (dp_v && dp_w && dp_a == `LCS_OFF_IMSK) begin
        sh_msk <= hwdata[2:0];
      end
    end
  end
  assign rd_ctrl = dp_v && !dp_w && dp_a == `LCS_OFF_CTRL;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  no_wait_a: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  unmapped_zero_a: assert property (dp_v && !dp_w && dp_a > `LCS_OFF_IMSK
    |-> hrdata == 32'h0) else $error("unmapped read not zero");
  ctrl_fields_a: assert property (rd_ctrl |->
    hrdata[15:11] == sh_rl && hrdata[1:0] == sh_fc)
    else $error("range, length or count lost");
  mode_field_a: assert property (rd_ctrl |-> hrdata[10:9] == sh_m ||
    (sh_m == 2'h1 && hrdata[10:9] == 2'h0)) else $error("bad mode");
  ctrl_zero_a: assert property (rd_ctrl |-> hrdata[31:16] == 16'h0 &&
    hrdata[5:2] == 4'h0) else $error("control spare bits not zero");
  result_upper_a: assert property (dp_v && !dp_w && dp_a == `LCS_OFF_RES
    |-> hrdata[31:16] == 16'h0) else $error("result upper bits set");
  irq_masked_a: assert property (sh_msk == 3'h0 && $past(sh_msk) == 3'h0
    |-> !irq) else $error("interrupt with all masked");
endmodule

bind lcs_ctrl lcs_ctrl_props u_props (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .irq(irq)
);

// ---- dv/tb.sv ----
// self-checking bench for the light conversion controller
// assumes: short conversion counts; checker bound from its own file
`timescale 1ns/1ps
`include "lcs_regs.svh"
module tb;
  localparam int SC = 20;
  localparam int LC = 40;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, ovl;
  logic [31:0] haddr, hwdata, hrdata, rdv, exp_ctrl;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] lvl;
  int err_count, cmp_count, ns, nl;
  assign hready = hreadyout;
  lcs_ctrl #(.SHORT_CYC(SC), .LONG_CYC(LC)) dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .light_overload(ovl),
    .light_level(lvl),
    .irq(irq)
  );
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  // waits for hready at an edge; a hung slave ends the run
  task automatic rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad("bus hang");
        wrap_up();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    rdv = hrdata;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp_count++;
    if (rdv !== e) bad($sformatf("at %h got %h want %h", a, rdv, e));
  endtask
  // control write, then drop sticky status left from the old setting
  task automatic go(input logic [31:0] v);
    bus(1'b1, `LCS_OFF_CTRL, v);
    bus(1'b1, `LCS_OFF_IST, 32'h7);
  endtask
  // polls the done status bit so the control flag is not read away
  task automatic wait_done(output int n);
    n = 0;
    rdv = 32'h0;
    while (rdv[`LCS_IRQ_DONE] !== 1'b1) begin
      if (n > 400) begin
        bad("no conversion end");
        wrap_up();
      end
      bus(1'b0, `LCS_OFF_IST, 32'h0);
      n++;
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ovl = 1'b0;
    lvl = 12'h123;
    err_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(`LCS_OFF_CTRL, 32'hc800);
    chk(`LCS_OFF_HLIM, 32'hbfff);
    chk(`LCS_OFF_IMSK, 32'h0);
    bus(1'b1, 8'h40, 32'hffff);
    chk(8'h40, 32'h0);
    bus(1'b1, `LCS_OFF_HLIM, 32'h0100);
    bus(1'b1, `LCS_OFF_IMSK, 32'h1);
    // single short conversion at the top manual range
    go(32'hb200);
    chk(`LCS_OFF_CTRL, 32'hb200);
    wait_done(ns);
    repeat (2) @(posedge hclk);
    cmp_count++;
    if (irq !== 1'b1) bad("interrupt not raised");
    chk(`LCS_OFF_CTRL, 32'hb0c0);
    chk(`LCS_OFF_CTRL, 32'hb040);
    chk(`LCS_OFF_RES, 32'hb123);
    bus(1'b1, `LCS_OFF_IST, 32'h7);
    repeat (2) @(posedge hclk);
    cmp_count++;
    if (irq !== 1'b0) bad("interrupt not cleared");
    // long conversion takes visibly more polls, same result layout
    go(32'hba00);
    wait_done(nl);
    cmp_count++;
    if (nl <= ns + 5) bad("long conversion not longer");
    chk(`LCS_OFF_CTRL, 32'hb8c0);
    chk(`LCS_OFF_RES, 32'hb123);
    // manual range overload saturates and flags overrange
    ovl <= 1'b1;
    go(32'h3200);
    wait_done(ns);
    chk(`LCS_OFF_CTRL, 32'h31c0);
    chk(`LCS_OFF_RES, 32'h3ffc);
    // automatic ranging climbs to the top and still overflows
    go(32'hc200);
    wait_done(ns);
    chk(`LCS_OFF_CTRL, 32'hc1c0);
    chk(`LCS_OFF_RES, 32'hbfff);
    ovl <= 1'b0;
    repeat (4) @(posedge hclk);
    go(32'hc200);
    wait_done(ns);
    chk(`LCS_OFF_CTRL, 32'hc0c0);
    chk(`LCS_OFF_RES, 32'h0120);
    // every fault count code in continuous mode
    for (int f = 0; f < 4; f++) begin
      lvl <= 12'h000;
      go(32'hb200 | f);
      wait_done(ns);
      lvl <= 12'h123;
      go(32'hb400 | f);
      for (int k = 1; k <= (1 << f); k++) begin
        wait_done(ns);
        bus(1'b1, `LCS_OFF_IST, 32'h7);
        exp_ctrl = 32'hb480 | f | ((k == (1 << f)) ? 32'h40 : 32'h0);
        chk(`LCS_OFF_CTRL, exp_ctrl);
      end
    end
    // shutdown write keeps done and above flags
    wait_done(ns);
    bus(1'b1, `LCS_OFF_CTRL, 32'hb003);
    chk(`LCS_OFF_CTRL, 32'hb0c3);
    // a write mid conversion aborts it
    go(32'hba00);
    repeat (5) @(posedge hclk);
    go(32'hb800);
    repeat (3 * LC) @(posedge hclk);
    chk(`LCS_OFF_IST, 32'h0);
    bus(1'b1, `LCS_OFF_IMSK, 32'h0);
    wrap_up();
  end
endmodule
